// File: design/bpe_map.svh
// Constants for the bridge parity error handler: status bit positions, reset values, timing.
`ifndef BPE_MAP_SVH
`define BPE_MAP_SVH

// =====================================================================
// Status flag positions
`define BPE_ST_P_DET     0
`define BPE_ST_P_SIG     1
`define BPE_ST_P_DPD     2
`define BPE_ST_S_DET     3
`define BPE_ST_S_DPD     4
`define BPE_ST_W         5
`define BPE_ST_RST       5'h00

// =====================================================================
// Widths and timing
`define BPE_AD_W         32
`define BPE_CBE_W        4
`define BPE_PERR_DLY     2

`endif

// File: design/bpe_pkg.sv
// Types and the shared parity check for the bridge parity error handler.
`include "bpe_map.svh"

package bpe_pkg;

    typedef logic [`BPE_AD_W-1:0]  bpe_ad_t;
    typedef logic [`BPE_CBE_W-1:0] bpe_cbe_t;
    typedef logic [`BPE_ST_W-1:0]  bpe_stat_t;

    // Even parity covers address/data, byte enables and the parity bit.
    function automatic logic bpe_par_bad(
        input bpe_ad_t  ad,
        input bpe_cbe_t cbe,
        input logic     par
    );
        bpe_par_bad = ^{ad, cbe, par};
    endfunction

endpackage

// File: design/bpe_side.sv
// One receiving bus side: data parity check, delayed parity error, read return holding entry.
`timescale 1ns/1ps
`default_nettype none
`include "bpe_map.svh"

module bpe_side #(
    parameter int PERR_DLY = `BPE_PERR_DLY
) (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire logic            perr_resp,
    input  wire logic            rx_valid,
    input  wire logic            chk_valid,
    input  wire bpe_pkg::bpe_ad_t  ad,
    input  wire bpe_pkg::bpe_cbe_t cbe,
    input  wire logic            par,
    input  wire logic            take,
    input  wire logic            discard,
    output logic                 rx_ready,
    output logic                 data_err,
    output logic                 err_on_read,
    output logic                 perr_n,
    output logic                 fwd_valid,
    output bpe_pkg::bpe_ad_t     fwd_ad,
    output bpe_pkg::bpe_cbe_t    fwd_cbe,
    output logic                 fwd_par
);
    import bpe_pkg::*;

    // =================================================================
    // Data parity check and delayed report
    logic                 accept;
    logic                 bad;
    logic [PERR_DLY-1:0]  perr_sr_n_ff;
    logic [PERR_DLY-1:0]  nxt_perr_sr_n;
    logic                 data_err_ff;
    logic                 nxt_data_err;
    logic                 err_rd_ff;
    logic                 nxt_err_rd;

    // The ready flag alone gates capture; parity never stalls the read.
    assign accept = rx_valid & rx_ready;
    assign bad    = bpe_par_bad(ad, cbe, par);

    // The shift chain is active low so the pin comes straight off a flop.
    always_comb begin
        nxt_data_err = (accept | chk_valid) & bad;
        nxt_err_rd   = accept & bad;
        nxt_perr_sr_n = {perr_sr_n_ff[PERR_DLY-2:0], ~(nxt_data_err & perr_resp)};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            perr_sr_n_ff <= '1;
            data_err_ff  <= 1'b0;
            err_rd_ff    <= 1'b0;
        end else begin
            perr_sr_n_ff <= nxt_perr_sr_n;
            data_err_ff  <= nxt_data_err;
            err_rd_ff    <= nxt_err_rd;
        end
    end

    assign perr_n      = perr_sr_n_ff[PERR_DLY-1];
    assign data_err    = data_err_ff;
    assign err_on_read = err_rd_ff;

    // =================================================================
    // Read return holding entry
    logic      hold_vld_ff;
    logic      nxt_hold_vld;
    bpe_ad_t   hold_ad_ff;
    bpe_ad_t   nxt_hold_ad;
    bpe_cbe_t  hold_cbe_ff;
    bpe_cbe_t  nxt_hold_cbe;
    logic      hold_par_ff;
    logic      nxt_hold_par;
    logic      ready_ff;
    logic      nxt_ready;
    logic      fv_ff;
    logic      nxt_fv;
    bpe_ad_t   fad_ff;
    bpe_ad_t   nxt_fad;
    bpe_cbe_t  fcbe_ff;
    bpe_cbe_t  nxt_fcbe;
    logic      fpar_ff;
    logic      nxt_fpar;

    always_comb begin
        nxt_hold_vld = hold_vld_ff;
        nxt_hold_ad  = hold_ad_ff;
        nxt_hold_cbe = hold_cbe_ff;
        nxt_hold_par = hold_par_ff;
        nxt_fv       = 1'b0;
        nxt_fad      = fad_ff;
        nxt_fcbe     = fcbe_ff;
        nxt_fpar     = fpar_ff;
        if (accept) begin
            nxt_hold_vld = 1'b1;
            nxt_hold_ad  = ad;
            nxt_hold_cbe = cbe;
            nxt_hold_par = par;
        end else if (hold_vld_ff && take) begin
            nxt_hold_vld = 1'b0;
            nxt_fv       = 1'b1;
            nxt_fad      = hold_ad_ff;
            nxt_fcbe     = hold_cbe_ff;
            nxt_fpar     = hold_par_ff;
        end else if (discard) begin
            nxt_hold_vld = 1'b0;
        end
        nxt_ready = ~nxt_hold_vld;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_vld_ff <= 1'b0;
            hold_ad_ff  <= '0;
            hold_cbe_ff <= '0;
            hold_par_ff <= 1'b0;
            ready_ff    <= 1'b1;
            fv_ff       <= 1'b0;
            fad_ff      <= '0;
            fcbe_ff     <= '0;
            fpar_ff     <= 1'b0;
        end else begin
            hold_vld_ff <= nxt_hold_vld;
            hold_ad_ff  <= nxt_hold_ad;
            hold_cbe_ff <= nxt_hold_cbe;
            hold_par_ff <= nxt_hold_par;
            ready_ff    <= nxt_ready;
            fv_ff       <= nxt_fv;
            fad_ff      <= nxt_fad;
            fcbe_ff     <= nxt_fcbe;
            fpar_ff     <= nxt_fpar;
        end
    end

    assign rx_ready  = ready_ff;
    assign fwd_valid = fv_ff;
    assign fwd_ad    = fad_ff;
    assign fwd_cbe   = fcbe_ff;
    assign fwd_par   = fpar_ff;

endmodule
`default_nettype wire

// File: design/bpe_top.sv
// Top of the bridge parity error handler: address checks, claims, system error, status.
`timescale 1ns/1ps
`default_nettype none
`include "bpe_map.svh"

module bpe_top #(
    parameter int PERR_DLY = `BPE_PERR_DLY
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Configuration bits.
    input  wire logic               p_par_resp,
    input  wire logic               s_par_resp,
    input  wire logic               primary_system_error_n_en,
    input  wire bpe_pkg::bpe_stat_t status_clr,
    // Primary bus phases.
    input  wire logic               p_addr_valid,
    input  wire logic               p_claim,
    input  wire bpe_pkg::bpe_ad_t   p_ad,
    input  wire bpe_pkg::bpe_cbe_t  p_cbe,
    input  wire logic               p_par,
    input  wire logic               p_cfg_wr,
    input  wire logic               p_up_rd_valid,
    input  wire logic               p_rd_take,
    input  wire logic               p_rd_discard,
    // Secondary bus phases.
    input  wire logic               s_addr_valid,
    input  wire logic               s_claim,
    input  wire bpe_pkg::bpe_ad_t   s_ad,
    input  wire bpe_pkg::bpe_cbe_t  s_cbe,
    input  wire logic               s_par,
    input  wire logic               s_dn_rd_valid,
    input  wire logic               s_rd_take,
    input  wire logic               s_rd_discard,
    // Bus-facing results.
    output logic                    primary_device_select_n,
    output logic                    secondary_device_select_n,
    output logic                    primary_system_error_n,
    output logic                    primary_parity_error_n,
    output logic                    secondary_parity_error_n,
    output logic                    primary_target_ready_n,
    output logic                    cfg_wr_stb,
    output bpe_pkg::bpe_ad_t        cfg_wr_data,
    output logic                    p_up_rd_ready,
    output logic                    s_dn_rd_ready,
    output logic                    p_ret_valid,
    output bpe_pkg::bpe_ad_t        p_ret_ad,
    output bpe_pkg::bpe_cbe_t       p_ret_cbe,
    output logic                    p_ret_par,
    output logic                    s_ret_valid,
    output bpe_pkg::bpe_ad_t        s_ret_ad,
    output bpe_pkg::bpe_cbe_t       s_ret_cbe,
    output logic                    s_ret_par,
    output bpe_pkg::bpe_stat_t      status
);
    import bpe_pkg::*;

    // =================================================================
    // Address parity
    logic p_ape;
    logic s_ape;

    assign p_ape = p_addr_valid & bpe_par_bad(p_ad, p_cbe, p_par);
    assign s_ape = s_addr_valid & bpe_par_bad(s_ad, s_cbe, s_par);

    // =================================================================
    // Receiving sides
    logic p_derr;
    logic p_derr_rd;
    logic s_derr;
    logic s_derr_rd;

    // Primary side checks upstream read data and own config writes and
    // returns upstream read data to the secondary initiator.
    bpe_side #(
        .PERR_DLY (PERR_DLY)
    ) u_pside (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .perr_resp   (p_par_resp),
        .rx_valid    (p_up_rd_valid),
        .chk_valid   (p_cfg_wr),
        .ad          (p_ad),
        .cbe         (p_cbe),
        .par         (p_par),
        .take        (s_rd_take),
        .discard     (s_rd_discard),
        .rx_ready    (p_up_rd_ready),
        .data_err    (p_derr),
        .err_on_read (p_derr_rd),
        .perr_n      (primary_parity_error_n),
        .fwd_valid   (s_ret_valid),
        .fwd_ad      (s_ret_ad),
        .fwd_cbe     (s_ret_cbe),
        .fwd_par     (s_ret_par)
    );

    // Secondary side only ever checks downstream read data here.
    bpe_side #(
        .PERR_DLY (PERR_DLY)
    ) u_sside (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .perr_resp   (s_par_resp),
        .rx_valid    (s_dn_rd_valid),
        .chk_valid   (1'b0),
        .ad          (s_ad),
        .cbe         (s_cbe),
        .par         (s_par),
        .take        (p_rd_take),
        .discard     (p_rd_discard),
        .rx_ready    (s_dn_rd_ready),
        .data_err    (s_derr),
        .err_on_read (s_derr_rd),
        .perr_n      (secondary_parity_error_n),
        .fwd_valid   (p_ret_valid),
        .fwd_ad      (p_ret_ad),
        .fwd_cbe     (p_ret_cbe),
        .fwd_par     (p_ret_par)
    );

    // reads always finish
    // A bad read beat never changes termination; ready follows only the
    // holding entry, so the target-bus read completes as usual.
    // initiator errors ignored
    // The return path has no input for the initiator's parity error at all:
    // once the data is handed over the initiator owns the problem.

    // =================================================================
    // Claims, system error and configuration write response
    logic     pdev_n_ff;
    logic     nxt_pdev_n;
    logic     sdev_n_ff;
    logic     nxt_sdev_n;
    logic     serr_n_ff;
    logic     nxt_serr_n;
    logic     serr_evt;
    logic     trdy_n_ff;
    logic     nxt_trdy_n;
    logic     cfg_stb_ff;
    logic     nxt_cfg_stb;
    bpe_ad_t  cfg_dat_ff;
    bpe_ad_t  nxt_cfg_dat;

    always_comb begin
        nxt_pdev_n = ~(p_addr_valid & p_claim & ~(p_ape & p_par_resp));
        nxt_sdev_n = ~(s_addr_valid & s_claim & ~(s_ape & s_par_resp));
        serr_evt   = primary_system_error_n_en & ((p_ape & p_par_resp) | (s_ape & s_par_resp));
        nxt_serr_n = ~serr_evt;
        nxt_trdy_n  = ~p_cfg_wr;
        nxt_cfg_stb = p_cfg_wr;
        nxt_cfg_dat = p_cfg_wr ? p_ad : cfg_dat_ff;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pdev_n_ff  <= 1'b1;
            sdev_n_ff  <= 1'b1;
            serr_n_ff  <= 1'b1;
            trdy_n_ff  <= 1'b1;
            cfg_stb_ff <= 1'b0;
            cfg_dat_ff <= '0;
        end else begin
            pdev_n_ff  <= nxt_pdev_n;
            sdev_n_ff  <= nxt_sdev_n;
            serr_n_ff  <= nxt_serr_n;
            trdy_n_ff  <= nxt_trdy_n;
            cfg_stb_ff <= nxt_cfg_stb;
            cfg_dat_ff <= nxt_cfg_dat;
        end
    end

    assign primary_device_select_n   = pdev_n_ff;
    assign secondary_device_select_n = sdev_n_ff;
    assign primary_system_error_n    = serr_n_ff;
    assign primary_target_ready_n    = trdy_n_ff;
    assign cfg_wr_stb                = cfg_stb_ff;
    assign cfg_wr_data               = cfg_dat_ff;

    // =================================================================
    // Status flags
    bpe_stat_t stat_ff;
    bpe_stat_t nxt_stat;
    bpe_stat_t stat_set;

    // Data errors arrive one cycle after the beat, so the response bits are
    // those standing then; software should not flip them mid-transfer.
    always_comb begin
        stat_set = '0;
        stat_set[`BPE_ST_P_DET] = p_ape | p_derr;
        stat_set[`BPE_ST_P_SIG] = serr_evt;
        stat_set[`BPE_ST_P_DPD] = p_derr_rd & p_par_resp;
        stat_set[`BPE_ST_S_DET] = s_ape | s_derr;
        stat_set[`BPE_ST_S_DPD] = s_derr_rd & s_par_resp;
        // write one clears
        // A set in the same cycle as its clear wins, so no event is lost.
        nxt_stat = (stat_ff & ~status_clr) | stat_set;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_ff <= `BPE_ST_RST;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign status = stat_ff;

endmodule
`default_nettype wire

// File: testbench/bpe_monitor.sv
// Port checker for the bridge parity error handler.
`timescale 1ns/1ps
`default_nettype none

module bpe_monitor (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              p_par_resp,
    input wire logic              s_par_resp,
    input wire logic              primary_system_error_n_en,
    input wire logic              p_addr_valid,
    input wire logic              p_claim,
    input wire bpe_pkg::bpe_ad_t  p_ad,
    input wire bpe_pkg::bpe_cbe_t p_cbe,
    input wire logic              p_par,
    input wire logic              p_cfg_wr,
    input wire logic              s_addr_valid,
    input wire logic              s_claim,
    input wire bpe_pkg::bpe_ad_t  s_ad,
    input wire bpe_pkg::bpe_cbe_t s_cbe,
    input wire logic              s_par,
    input wire logic              s_dn_rd_valid,
    input wire logic              s_dn_rd_ready,
    input wire logic              primary_device_select_n,
    input wire logic              secondary_device_select_n,
    input wire logic              primary_system_error_n,
    input wire logic              primary_parity_error_n,
    input wire logic              secondary_parity_error_n,
    input wire logic              primary_target_ready_n,
    input wire logic              cfg_wr_stb,
    input wire bpe_pkg::bpe_ad_t  cfg_wr_data,
    input wire bpe_pkg::bpe_stat_t status
);
    import bpe_pkg::*;

    // =================================================================
    // Parity of each bus phase, even over data, enables and parity.
    wire logic pb = ^{p_ad, p_cbe, p_par};
    wire logic sb = ^{s_ad, s_cbe, s_par};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence p_bad_addr;
        p_addr_valid && pb;
    endsequence
    sequence dn_bad_beat;
        s_dn_rd_valid && s_dn_rd_ready && sb;
    endsequence

    // =================================================================
    // Address phase, config write and read data relations.
    a_pclaim_drop: assert property (p_bad_addr ##0 (p_claim && p_par_resp)
        |=> primary_device_select_n) else $error("primary claim kept");
    a_pclaim_keep: assert property (p_addr_valid && p_claim &&
        !(pb && p_par_resp) |=> !primary_device_select_n)
        else $error("primary claim lost");
    a_sclaim_drop: assert property (s_addr_valid && s_claim && sb &&
        s_par_resp |=> secondary_device_select_n) else $error("sec claim kept");
    a_pdet_flag: assert property (p_bad_addr |=> status[0])
        else $error("primary detect flag missing");
    a_psys_err: assert property (p_bad_addr ##0 (primary_system_error_n_en && p_par_resp)
        |=> !primary_system_error_n && status[1]) else $error("no serr");
    a_ssys_err: assert property (s_addr_valid && sb && primary_system_error_n_en &&
        s_par_resp |=> !primary_system_error_n) else $error("no sec serr");
    a_sdet_flag: assert property (s_addr_valid && sb |=> status[3])
        else $error("secondary detect flag missing");
    a_cfg_ready: assert property (p_cfg_wr |=> !primary_target_ready_n &&
        cfg_wr_stb && cfg_wr_data == $past(p_ad)) else $error("cfg write lost");
    a_cfg_perr: assert property (p_cfg_wr && pb && p_par_resp |=> ##1
        !primary_parity_error_n && status[0]) else $error("cfg perr missing");
    a_dn_perr: assert property (dn_bad_beat ##0 s_par_resp |-> ##2
        !secondary_parity_error_n ##1 secondary_parity_error_n)
        else $error("downstream perr timing");
endmodule

`default_nettype wire

// File: testbench/bpe_sec_agent.sv
// Secondary bus agent: address phases and downstream read data beats.
`timescale 1ns/1ps
`default_nettype none

module bpe_sec_agent (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [1:0]        req,
    input  wire logic              req_bad,
    input  wire logic              req_claim,
    input  wire bpe_pkg::bpe_ad_t  req_ad,
    input  wire logic              s_dn_rd_ready,
    output logic                   s_addr_valid,
    output logic                   s_claim,
    output logic                   s_dn_rd_valid,
    output bpe_pkg::bpe_ad_t       s_ad,
    output bpe_pkg::bpe_cbe_t      s_cbe,
    output logic                   s_par
);
    import bpe_pkg::*;

    // =================================================================
    // A beat is held until ready is seen; a released bus is inverted so
    // that stale values never look valid.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_addr_valid <= 1'b0;
            s_claim <= 1'b0;
            s_dn_rd_valid <= 1'b0;
            s_ad <= 32'h0;
            s_cbe <= 4'h0;
            s_par <= 1'b0;
        end else begin
            s_addr_valid <= 1'b0;
            if (s_addr_valid || (s_dn_rd_valid && s_dn_rd_ready)) begin
                s_dn_rd_valid <= 1'b0;
                s_ad <= ~s_ad;
                s_cbe <= ~s_cbe;
                s_par <= ~s_par;
            end
            if (req != 2'h0) begin
                s_addr_valid <= (req == 2'h1);
                s_dn_rd_valid <= (req == 2'h2);
                s_claim <= req_claim;
                s_ad <= req_ad;
                s_cbe <= 4'h6;
                s_par <= ^{req_ad, 4'h6} ^ req_bad;
            end
        end
    end
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the bridge parity error handler.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    error_cnt++; $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end

module tb_top;
    import bpe_pkg::*;
    logic      clk_sys, rst, p_par_resp, s_par_resp, primary_system_error_n_en, req_bad;
    logic      p_addr_valid, p_claim, p_par, p_cfg_wr, p_up_rd_valid;
    logic      p_rd_take, p_rd_discard, s_rd_take, s_rd_discard, req_claim;
    logic      s_addr_valid, s_claim, s_par, s_dn_rd_valid, cfg_wr_stb;
    logic      primary_device_select_n, secondary_device_select_n;
    logic      primary_system_error_n, primary_parity_error_n;
    logic      secondary_parity_error_n, primary_target_ready_n;
    logic      p_up_rd_ready, s_dn_rd_ready, p_ret_valid, s_ret_valid;
    logic      p_ret_par, s_ret_par;
    logic [1:0] req;
    bpe_stat_t status_clr, status;
    bpe_ad_t   p_ad, s_ad, req_ad, cfg_wr_data, p_ret_ad, s_ret_ad, ad;
    bpe_cbe_t  p_cbe, s_cbe, p_ret_cbe, s_ret_cbe;
    logic [36:0] exp_q[$];
    int        error_cnt, samples_checked, seed, i;

    bpe_top #(.PERR_DLY(2)) dut (.*);
    bpe_sec_agent u_sec (.*);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Clears every sticky flag and expects the whole vector at zero.
    task automatic clr_all;
        @(posedge clk_sys) status_clr <= 5'h1F;
        @(posedge clk_sys) status_clr <= 5'h00;
        @(negedge clk_sys);
        `CHK(status, 5'h00)
    endtask

    // Bounds the run so a stuck design still reaches the verdict.
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        stop_test();
    end

    initial begin
        {rst, p_par_resp, s_par_resp, primary_system_error_n_en, req_bad, req_claim} = 6'h20;
        {p_addr_valid, p_claim, p_par, p_cfg_wr, p_up_rd_valid} = 5'h00;
        {p_rd_take, p_rd_discard, s_rd_take, s_rd_discard} = 4'h0;
        {req, status_clr, p_ad, req_ad, p_cbe} = '0;
        seed = 32'hD422;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        `CHK(status, 5'h00)
        // Address phases on both buses, all enable and parity mixes.
        for (i = 0; i < 8; i++) begin
            ad = $random(seed);
            @(posedge clk_sys) begin
                {primary_system_error_n_en, p_par_resp, s_par_resp} <= {i[2], i[1], i[1]};
                {p_addr_valid, p_claim, p_ad, p_cbe} <= {2'h3, ad, 4'h7};
                p_par <= ^{ad, 4'h7} ^ i[0];
            end
            @(posedge clk_sys) p_addr_valid <= 1'b0;
            @(negedge clk_sys);
            `CHK(primary_device_select_n, i[0] & i[1])
            `CHK(primary_system_error_n, !(i[0] && i[1] && i[2]))
            `CHK(status, {3'h0, i[0] & i[1] & i[2], i[0]})
            clr_all();
            @(posedge clk_sys) {req, req_bad, req_claim, req_ad} <= {3'h2 | i[0], 1'b1, ad};
            @(posedge clk_sys) req <= 2'h0;
            @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK(secondary_device_select_n, i[0] & i[1])
            `CHK(primary_system_error_n, !(i[0] && i[1] && i[2]))
            `CHK(status, {1'b0, i[0], 1'b0, i[0] & i[1] & i[2], 1'b0})
            clr_all();
        end
        // Config writes: always accepted, error reported when enabled.
        for (i = 0; i < 4; i++) begin
            ad = $random(seed);
            @(posedge clk_sys) begin
                {p_par_resp, p_cfg_wr, p_ad, p_cbe} <= {i[1], 1'b1, ad, 4'hF};
                p_par <= ^{ad, 4'hF} ^ i[0];
            end
            @(posedge clk_sys) p_cfg_wr <= 1'b0;
            @(negedge clk_sys);
            `CHK({primary_target_ready_n, cfg_wr_stb, cfg_wr_data}, {2'h1, ad})
            @(negedge clk_sys);
            `CHK(primary_parity_error_n, !(i[0] && i[1]))
            `CHK(status, {4'h0, i[0]})
            clr_all();
        end
        // Reads both ways at once; a refused second beat, then return, or discard when i is 1.
        for (i = 0; i < 4; i++) begin
            ad = $random(seed);
            @(posedge clk_sys) begin
                {p_par_resp, s_par_resp, req, req_bad} <= {i[1], i[1], 2'h2, i[0]};
                req_ad <= ad;
            end
            exp_q.push_back({ad, 4'h6, ^{ad, 4'h6} ^ i[0]});
            @(posedge clk_sys) begin
                {req, p_up_rd_valid, p_ad, p_cbe} <= {3'h1, ~ad, 4'h3};
                p_par <= ^{~ad, 4'h3} ^ i[0];
            end
            exp_q.push_back({~ad, 4'h3, ^{~ad, 4'h3} ^ i[0]});
            @(posedge clk_sys) begin
                p_ad <= ad;
                p_par <= ^{ad, 4'h3} ^ 1'b1;
            end
            @(posedge clk_sys) p_up_rd_valid <= 1'b0;
            @(negedge clk_sys);
            `CHK({primary_parity_error_n, secondary_parity_error_n}, {2{!(i[0] && i[1])}})
            `CHK(status, {i[0] & i[1], i[0], i[0] & i[1], 1'b0, i[0]})
            `CHK({p_up_rd_ready, s_dn_rd_ready}, 2'h0)
            @(posedge clk_sys) {p_rd_take, s_rd_take, p_rd_discard, s_rd_discard} <= (i == 1) ? 4'h3 : 4'hC;
            @(posedge clk_sys) {p_rd_take, s_rd_take, p_rd_discard, s_rd_discard} <= 4'h0;
            @(negedge clk_sys);
            `CHK({p_ret_valid, s_ret_valid}, {2{i != 1}})
            `CHK({p_up_rd_ready, s_dn_rd_ready}, 2'h3)
            if (i != 1) `CHK({p_ret_ad, p_ret_cbe, p_ret_par}, exp_q[0])
            if (i != 1) `CHK({s_ret_ad, s_ret_cbe, s_ret_par}, exp_q[1])
            // The initiator sees bad parity exactly when the target sent it.
            if (i != 1) `CHK(^{p_ret_ad, p_ret_cbe, p_ret_par}, i[0])
            if (i != 1) `CHK(^{s_ret_ad, s_ret_cbe, s_ret_par}, i[0])
            exp_q.delete();
            clr_all();
        end
        stop_test();
    end
endmodule

bind bpe_top bpe_monitor u_mon (.*);

`default_nettype wire
